/* hw/sat_clock_pkg.sv */
// constants, field layouts and types shared by the satellite clock block
package sat_clock_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS     = 10;
	localparam int MS_NS             = 1000000;
	localparam int MS_CYCLES_DEF     = MS_NS / CLK_PERIOD_NS;
	localparam int KHZ_HIGH_NS       = 100000;
	localparam int KHZ_HIGH_CYC_DEF  = KHZ_HIGH_NS / CLK_PERIOD_NS;
	localparam int PPS_HIGH_MS       = 100;
	localparam int MS_PER_SEC        = 1000;
	localparam int BLINK_ON_MS       = 500;
	localparam int SWEEP_S           = 150;
	localparam int FRAME_S           = 30;
	localparam int SEC_PER_DHOUR     = 360;
	localparam int COLON_AGE_DHOUR   = 139;
	localparam int FULL_AGE_DHOUR    = 1389;
	localparam int COLON_AGE_S_DEF   = COLON_AGE_DHOUR * SEC_PER_DHOUR;
	localparam int FULL_AGE_S_DEF    = FULL_AGE_DHOUR * SEC_PER_DHOUR;
	localparam int DELAY_ZERO        = 50;
	localparam int DAYS_MAX          = 366;

	// ****************************************************************
	// register map (byte addresses) and fields
	// ****************************************************************
	localparam logic [7:0]  ADR_CTRL      = 8'h00;
	localparam logic [7:0]  ADR_STATUS    = 8'h04;
	localparam logic [7:0]  ADR_TIME      = 8'h08;
	localparam logic [7:0]  ADR_AGE       = 8'h0c;
	localparam logic [7:0]  ADR_IRQ_STAT  = 8'h10;
	localparam logic [7:0]  ADR_IRQ_MASK  = 8'h14;
	localparam logic [15:0] CTRL_RST      = 16'h5000;
	localparam int          CTRL_OFS_LSB  = 0;
	localparam int          CTRL_H12_BIT  = 5;
	localparam int          CTRL_EAST_BIT = 6;
	localparam int          CTRL_WEST_BIT = 7;
	localparam int          CTRL_UNIT_LSB = 8;
	localparam int          CTRL_TENS_LSB = 12;
	localparam int          IRQ_W         = 5;
	localparam int          IRQ_LIT       = 0;
	localparam int          IRQ_SYNC      = 1;
	localparam int          IRQ_MISMATCH  = 2;
	localparam int          IRQ_COLON     = 3;
	localparam int          IRQ_FULL      = 4;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef struct packed {
		logic [8:0] day;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} tod_s;

	typedef struct packed {
		logic carrier_lock;
		logic data_lock;
		logic mls_seen;
		logic frame_stb;
		tod_s frame;
	} rx_pins_s;

	typedef enum logic [1:0] {
		ST_BLANK = 2'b01,
		ST_SHOWN = 2'b10
	} disp_state_e;

endpackage : sat_clock_pkg

/* hw/sat_clock.sv */
// satellite clock time keeping, display control, pulses and register slave
`timescale 1ns/1ns

// Summary of operation
// - display stays blank after reset until a valid time exists.
// - light display only with carrier lock, data lock and two agreeing frames.
// - show day, hour, minute, second based on universal time.
// - after 13.9 unlocked hours since sync, flash the colons.
// - after 138.9 unlocked hours since sync, flash the whole display.
// - any flashing stops by itself at the next locked, decoded sync.
// - add the signed hour offset before display; zero means unchanged.
// - every time output carries the same corrected time as the display.
// - hours on 24-hour base, 12-hour when selected.
// - east only, west only, or automatic scan of both satellites.
// - delay from two decimal digits, units and tens, up to 99 ms.
// - setting 50 is neutral; each step shifts output time by 1 ms.
// - one pulse per second, high 100 ms, low 900 ms.
// - 1 kHz wave, high 100 us, low 900 us, on millisecond edges.
// - colons blink while searching, steady once the sequence is seen.
module sat_clock #(
	parameter int MS_CYCLES    = sat_clock_pkg::MS_CYCLES_DEF,
	parameter int KHZ_HIGH_CYC = sat_clock_pkg::KHZ_HIGH_CYC_DEF,
	parameter int COLON_AGE_S  = sat_clock_pkg::COLON_AGE_S_DEF,
	parameter int FULL_AGE_S   = sat_clock_pkg::FULL_AGE_S_DEF
) (
	input  wire logic                     CLK,
	input  wire logic                     RST_N,
	input  wire logic                     CYC_I,
	input  wire logic                     STB_I,
	input  wire logic                     WE_I,
	input  wire logic [7:0]               ADR_I,
	input  wire logic [31:0]              DAT_I,
	input  wire logic [3:0]               SEL_I,
	output logic      [31:0]              DAT_O,
	output logic                          ACK_O,
	output logic                          IRQ,
	input  wire sat_clock_pkg::rx_pins_s  RX,
	output logic                          SAT_EAST,
	output logic                          DISP_ON,
	output logic                          COLON_ON,
	output logic                          PM,
	output sat_clock_pkg::tod_s           DISP_TIME,
	output logic                          PPS,
	output logic                          KHZ
);
	import sat_clock_pkg::*;

	// advances a time of year by n seconds, n below one minute
	function automatic tod_s add_sec(input tod_s t, input logic [5:0] n);
		tod_s r;
		logic [6:0] s;
		r = t;
		s = {1'b0, t.sec} + {1'b0, n};
		if (s >= 7'd60) begin
			r.sec = 6'(s - 7'd60);
			if (t.min == 6'd59) begin
				r.min = '0;
				if (t.hour == 5'd23) begin
					r.hour = '0;
					r.day = (t.day == 9'(DAYS_MAX)) ? 9'h001 : 9'(t.day + 9'h001);
				end else begin
					r.hour = 5'(t.hour + 5'h01);
				end
			end else begin
				r.min = 6'(t.min + 6'h01);
			end
		end else begin
			r.sec = 6'(s);
		end
		return r;
	endfunction : add_sec

	// ****************************************************************
	// receiver pin synchronisers
	// ****************************************************************
	// three stages per pin; the filtered copy moves only when two stages agree
	rx_pins_s    rx_s1;
	rx_pins_s    rx_s2;
	rx_pins_s    rx_s3;
	rx_pins_s    rx;
	rx_pins_s    next_rx;
	logic        stb_d;

	// a bit changes only once the second and third stages agree
	assign next_rx = (~(rx_s2 ^ rx_s3) & rx_s3) | ((rx_s2 ^ rx_s3) & rx);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rx_s1 <= '0;
			rx_s2 <= '0;
			rx_s3 <= '0;
			rx    <= '0;
			stb_d <= 1'b0;
		end else begin
			rx_s1 <= RX;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			rx    <= next_rx;
			stb_d <= rx.frame_stb;
		end
	end

	// ****************************************************************
	// control register fields
	// ****************************************************************
	logic [15:0]       ctrl;
	logic [IRQ_W-1:0]  irq_stat;
	logic [IRQ_W-1:0]  irq_mask;
	wire  [4:0]        hour_ofs = ctrl[CTRL_OFS_LSB +: 5];
	wire               h12_sel  = ctrl[CTRL_H12_BIT];
	wire               east_sel = ctrl[CTRL_EAST_BIT];
	wire               west_sel = ctrl[CTRL_WEST_BIT];
	wire  [3:0]        dly_unit = ctrl[CTRL_UNIT_LSB +: 4];
	wire  [3:0]        dly_tens = ctrl[CTRL_TENS_LSB +: 4];

	// delay setting as milliseconds, neutral at fifty
	// tens digit widened to 7 bits before scaling so the product of a decimal digit cannot wrap
	wire  [6:0]        dly_ms   = 7'(dly_tens) * 7'h0a + {3'h0, dly_unit};
	wire               dly_adv  = dly_ms >= 7'(DELAY_ZERO);
	wire  [6:0]        adv_ms   = 7'(dly_ms - 7'(DELAY_ZERO));
	wire  [6:0]        ret_ms   = 7'(7'(DELAY_ZERO) - dly_ms);

	// ****************************************************************
	// frame qualification
	// ****************************************************************
	disp_state_e  state;
	disp_state_e  next_state;
	tod_s         prev;
	logic         have_prev;
	wire          locked    = rx.carrier_lock & rx.data_lock;
	wire          frame_new = rx.frame_stb & ~stb_d;
	wire          agree     = have_prev & (rx.frame == add_sec(prev, 6'(FRAME_S)));
	wire          shown_now = state == ST_SHOWN;
	// once lit, the first locked frame after a lock loss resynchronises alone
	wire          resync    = frame_new & locked & shown_now & ~have_prev;
	wire          sync_evt  = (frame_new & locked & agree) | resync;
	// a mismatch needs an earlier locked frame to disagree with
	wire          mismatch  = frame_new & locked & have_prev & ~agree;

	// the display lights on the first agreeing frame and then stays lit
	assign next_state = (state == ST_BLANK && sync_evt) ? ST_SHOWN : state;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state     <= ST_BLANK;
			prev      <= '0;
			have_prev <= 1'b0;
		end else begin
			state <= next_state;
			if (frame_new && locked) begin
				prev      <= rx.frame;
				have_prev <= 1'b1;
			end else if (!locked) begin
				have_prev <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// running universal time with delay correction
	// ****************************************************************
	logic [31:0]  cyc;
	logic [9:0]   ms;
	tod_s         utc;
	logic         pend;
	logic [6:0]   pend_ms;
	tod_s         pend_time;
	wire          ms_tick  = cyc == 32'(MS_CYCLES - 1);
	wire          sec_tick = ms_tick & (ms == 10'(MS_PER_SEC - 1));
	wire          adv_load = sync_evt & dly_adv;
	wire          ret_load = pend & ms_tick & (pend_ms == 7'h01);

	// advance loads at once with a lead; retard waits whole milliseconds
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cyc       <= '0;
			ms        <= '0;
			utc       <= '{day: 9'h001, hour: 5'h00, min: 6'h00, sec: 6'h00};
			pend      <= 1'b0;
			pend_ms   <= '0;
			pend_time <= '0;
		end else begin
			if (sync_evt) begin
				cyc <= '0;
			end else if (ms_tick) begin
				cyc <= '0;
			end else begin
				cyc <= 32'(cyc + 32'h1);
			end
			if (adv_load) begin
				utc <= rx.frame;
				ms  <= {3'h0, adv_ms};
			end else if (ret_load) begin
				utc <= pend_time;
				ms  <= '0;
			end else if (sec_tick) begin
				utc <= add_sec(utc, 6'h01);
				ms  <= '0;
			end else if (ms_tick) begin
				ms  <= 10'(ms + 10'h001);
			end
			if (sync_evt && !dly_adv) begin
				pend      <= 1'b1;
				pend_ms   <= ret_ms;
				pend_time <= rx.frame;
			end else if (ret_load) begin
				pend      <= 1'b0;
			end else if (pend && ms_tick) begin
				pend_ms   <= 7'(pend_ms - 7'h01);
			end
		end
	end

	// ****************************************************************
	// unlocked age and satellite selection
	// ****************************************************************
	logic [19:0]  age;
	logic [7:0]   sweep;
	logic         scan_east;
	wire          colon_flash = (state == ST_SHOWN) & (age >= 20'(COLON_AGE_S));
	wire          full_flash  = (state == ST_SHOWN) & (age >= 20'(FULL_AGE_S));
	wire          colon_hit   = sec_tick & ~rx.data_lock & (age == 20'(COLON_AGE_S - 1));
	wire          full_hit    = sec_tick & ~rx.data_lock & (age == 20'(FULL_AGE_S - 1));
	wire          next_east   = east_sel | (~west_sel & scan_east);

	// age saturates at the full flash threshold so it never wraps
	// age restarts at every sync; auto mode swaps satellite after a sweep
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			age       <= '0;
			sweep     <= '0;
			scan_east <= 1'b0;
		end else begin
			if (sync_evt) begin
				age <= '0;
			end else if (sec_tick && !rx.data_lock && age < 20'(FULL_AGE_S)) begin
				age <= 20'(age + 20'h1);
			end
			if (rx.data_lock || east_sel || west_sel) begin
				sweep <= '0;
			end else if (sec_tick && sweep == 8'(SWEEP_S - 1)) begin
				sweep     <= '0;
				scan_east <= ~scan_east;
			end else if (sec_tick) begin
				sweep <= 8'(sweep + 8'h01);
			end
		end
	end

	// ****************************************************************
	// offset, 12/24 hour and display drive
	// ****************************************************************
	wire signed [6:0] hsum    = $signed({2'b00, utc.hour}) + $signed({{2{hour_ofs[4]}}, hour_ofs});
	wire              h_neg   = hsum < 7'sd0;
	wire              h_over  = hsum >= 7'sd24;
	wire        [4:0] h24     = h_neg ? 5'(hsum + 7'sd24) : h_over ? 5'(hsum - 7'sd24) : 5'(hsum);
	wire        [8:0] day_dec = (utc.day == 9'h001) ? 9'(DAYS_MAX) : 9'(utc.day - 9'h001);
	wire        [8:0] day_inc = (utc.day == 9'(DAYS_MAX)) ? 9'h001 : 9'(utc.day + 9'h001);
	wire        [8:0] day_ofs = h_neg ? day_dec : h_over ? day_inc : utc.day;
	wire        [4:0] h12     = (h24 == 5'h00) ? 5'h0c : (h24 > 5'h0c) ? 5'(h24 - 5'h0c) : h24;
	wire              blink   = ms < 10'(BLINK_ON_MS);
	wire              shown   = state == ST_SHOWN;
	wire              next_colon = shown ? (~colon_flash | blink) : (rx.mls_seen | blink);
	tod_s             next_disp;

	// corrected time feeds display and time register alike; pulse outputs follow ms and cyc
	assign next_disp = '{day: day_ofs, hour: h12_sel ? h12 : h24,
	                     min: utc.min, sec: utc.sec};

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DISP_ON   <= 1'b0;
			COLON_ON  <= 1'b0;
			PM        <= 1'b0;
			DISP_TIME <= '0;
			PPS       <= 1'b0;
			KHZ       <= 1'b0;
			SAT_EAST  <= 1'b0;
		end else begin
			DISP_ON   <= shown & (~full_flash | blink);
			COLON_ON  <= next_colon;
			PM        <= h24 >= 5'h0c;
			DISP_TIME <= next_disp;
			PPS       <= shown & (ms < 10'(PPS_HIGH_MS));
			KHZ       <= shown & (cyc < 32'(KHZ_HIGH_CYC));
			SAT_EAST  <= next_east;
		end
	end

	// ****************************************************************
	// wishbone slave and interrupts
	// ****************************************************************
	// a held request is answered every second cycle; the ack itself masks the next edge
	wire              req     = CYC_I & STB_I & ~ACK_O;
	wire              wr      = req & WE_I;
	wire              wr_ctrl = wr & (ADR_I == ADR_CTRL);
	wire              wr_stat = wr & (ADR_I == ADR_IRQ_STAT) & SEL_I[0];
	wire              wr_mask = wr & (ADR_I == ADR_IRQ_MASK) & SEL_I[0];
	wire [IRQ_W-1:0]  irq_evt = {full_hit, colon_hit, mismatch, sync_evt,
	                             sync_evt & (state == ST_BLANK)};
	wire [IRQ_W-1:0]  clr     = wr_stat ? DAT_I[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0]  next_irq_stat = (irq_stat & ~clr) | irq_evt;  // set wins over clear
	wire [31:0]       status_word = {24'h0, SAT_EAST, full_flash, colon_flash,
	                                 rx.mls_seen, rx.data_lock, rx.carrier_lock, 1'b0, shown};
	wire [31:0]       rd_data =
		(ADR_I == ADR_CTRL)     ? {16'h0, ctrl} :
		(ADR_I == ADR_STATUS)   ? status_word :
		(ADR_I == ADR_TIME)     ? {6'h0, DISP_TIME} :
		(ADR_I == ADR_AGE)      ? {12'h0, age} :
		(ADR_I == ADR_IRQ_STAT) ? {27'h0, irq_stat} :
		(ADR_I == ADR_IRQ_MASK) ? {27'h0, irq_mask} : 32'h0;

	// one-wait answer; write lanes follow the byte selects
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ACK_O    <= 1'b0;
			DAT_O    <= '0;
			IRQ      <= 1'b0;
			ctrl     <= CTRL_RST;
			irq_stat <= '0;
			irq_mask <= '0;
		end else begin
			ACK_O    <= req;
			DAT_O    <= (req && !WE_I) ? rd_data : 32'h0;
			irq_stat <= next_irq_stat;
			IRQ      <= |(next_irq_stat & irq_mask);
			if (wr_ctrl && SEL_I[0]) begin
				ctrl[7:0] <= DAT_I[7:0];
			end
			if (wr_ctrl && SEL_I[1]) begin
				ctrl[15:8] <= DAT_I[15:8];
			end
			if (wr_mask) begin
				irq_mask <= DAT_I[IRQ_W-1:0];
			end
		end
	end

endmodule : sat_clock

/* tb/sat_clock_monitor.sv */
// checker for the satellite clock outputs
`timescale 1ns/1ns
module sat_clock_monitor #(
	parameter int MS_CYCLES    = 20,
	parameter int KHZ_HIGH_CYC = 2
) (
	input wire logic                     CLK,
	input wire logic                     RST_N,
	input wire logic                     ACK_O,
	input wire sat_clock_pkg::rx_pins_s  RX,
	input wire logic                     DISP_ON,
	input wire logic                     COLON_ON,
	input wire logic                     PM,
	input wire sat_clock_pkg::tod_s      DISP_TIME,
	input wire logic                     PPS,
	input wire logic                     KHZ
);
	import sat_clock_pkg::*;
	localparam int PPS_CYC = PPS_HIGH_MS * MS_CYCLES;
	logic shown;
	int   pps_hi;
	int   khz_hi;
	// ****************************************************************
	// helper state and properties
	// ****************************************************************
	// display lit once, and run lengths of both pulse outputs
	always_ff @(posedge CLK) begin
		shown  <= RST_N && (shown || DISP_ON);
		pps_hi <= (RST_N && PPS) ? pps_hi + 1 : 0;
		khz_hi <= (RST_N && KHZ) ? khz_hi + 1 : 0;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	lit_needs_lock_a: assert property (!shown && $rose(DISP_ON) |-> RX.carrier_lock && RX.data_lock)
		else $error("display lit without lock");
	pulse_when_lit_a: assert property ($rose(PPS) |-> shown or ##[0:3] DISP_ON)
		else $error("second pulse before valid time");
	pps_width_a: assert property ($fell(PPS) |-> pps_hi <= PPS_CYC)
		else $error("second pulse too long");
	khz_width_a: assert property ($fell(KHZ) |-> khz_hi == KHZ_HIGH_CYC)
		else $error("millisecond pulse width wrong");
	pps_on_ms_a: assert property ($rose(PPS) |-> $rose(KHZ))
		else $error("second pulse off millisecond edge");
	pm_hour_a: assert property (DISP_TIME.hour > 12 |-> PM)
		else $error("afternoon flag missing");
	time_range_a: assert property (DISP_ON |-> DISP_TIME.hour < 24 && DISP_TIME.min < 60
		&& DISP_TIME.sec < 60 && DISP_TIME.day inside {[1:DAYS_MAX]}) else $error("time out of range");
	colon_steady_a: assert property (!shown && RX.mls_seen && $past(RX.mls_seen, 6) |-> COLON_ON)
		else $error("colons not steady");
	ack_pulse_a: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
endmodule : sat_clock_monitor

bind sat_clock sat_clock_monitor #(.MS_CYCLES(MS_CYCLES), .KHZ_HIGH_CYC(KHZ_HIGH_CYC))
	u_sat_clock_monitor (.CLK(CLK), .RST_N(RST_N), .ACK_O(ACK_O), .RX(RX), .DISP_ON(DISP_ON),
	.COLON_ON(COLON_ON), .PM(PM), .DISP_TIME(DISP_TIME), .PPS(PPS), .KHZ(KHZ));

/* tb/rx_model.sv */
// receiver model: lock levels and time frames toward the clock
`timescale 1ns/1ns
module rx_model (
	input wire logic                clk,
	output sat_clock_pkg::rx_pins_s rx
);
	import sat_clock_pkg::*;
	// ****************************************************************
	// receiver pins
	// ****************************************************************
	initial rx = '0;
	// lock levels as the receiver reports them
	task automatic set_lock(input logic c, input logic d, input logic m);
		@(posedge clk);
		rx.carrier_lock <= c;
		rx.data_lock    <= d;
		rx.mls_seen     <= m;
	endtask : set_lock
	// one whole frame, strobe on the instant, then stale inverted data
	task automatic send(input tod_s t);
		@(posedge clk);
		rx.frame <= t;
		repeat (4) @(posedge clk);
		rx.frame_stb <= 1'b1;
		repeat (8) @(posedge clk);
		rx.frame_stb <= 1'b0;
		repeat (4) @(posedge clk);
		rx.frame <= ~t;
	endtask : send
endmodule : rx_model

/* tb/test_sat_clock.sv */
// self-checking bench for the satellite clock
`timescale 1ns/1ns
module test_sat_clock;
	import sat_clock_pkg::*;
	localparam int MSC = 2;
	localparam int SEC = MS_PER_SEC * MSC;
	logic        CLK = 0, RST_N = 0, CYC_I = 0, STB_I = 0, WE_I = 0;
	logic [7:0]  ADR_I = '0;
	logic [31:0] DAT_I = '0, DAT_O, v;
	logic        ACK_O, IRQ, SAT_EAST, DISP_ON, COLON_ON, PM, PPS, KHZ;
	rx_pins_s    RX;
	tod_s        DISP_TIME;
	int          err_count = 0, comparisons = 0, cyc = 0, n, t1c;
	sat_clock #(.MS_CYCLES(MSC), .KHZ_HIGH_CYC(1), .COLON_AGE_S(3), .FULL_AGE_S(6)) u_sat_clock (
		.CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
		.DAT_I(DAT_I), .SEL_I(4'hf), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ), .RX(RX),
		.SAT_EAST(SAT_EAST), .DISP_ON(DISP_ON), .COLON_ON(COLON_ON), .PM(PM),
		.DISP_TIME(DISP_TIME), .PPS(PPS), .KHZ(KHZ));
	rx_model u_rx_model (.clk(CLK), .rx(RX));
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one classic bus cycle, read data left in v
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I  <= we;
		ADR_I <= a;
		DAT_I <= d;
		do @(posedge CLK); while (ACK_O !== 1'b1);
		v = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, '0);
		chk(v, e);
	endtask : rd
	// cycles that the chosen pulse output keeps level lvl
	task automatic meas(input logic k, input logic lvl);
		n = 0;
		while ((k ? KHZ : PPS) === lvl) begin
			@(posedge CLK);
			n++;
		end
	endtask : meas
	task automatic wait_until(input int t);
		while (cyc < t) @(posedge CLK);
	endtask : wait_until
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	// ****************************************************************
	// clock, timeout and test sequence
	// ****************************************************************
	initial begin
		forever #5 CLK = ~CLK;
	end
	// cycle counter with a ceiling against hangs
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 140000) begin
			err_count++;
			stop_test();
		end
	end
	initial begin
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		rd(ADR_CTRL, 32'h5000);
		rd(8'h20, '0);
		wb(1'b1, ADR_CTRL, 32'h6202);
		rd(ADR_CTRL, 32'h6202);
		wb(1'b1, ADR_IRQ_MASK, 32'h1);
		n = COLON_ON;
		repeat (SEC / 2) @(posedge CLK);
		chk(COLON_ON, !n);
		u_rx_model.set_lock(1'b1, 1'b1, 1'b1);
		repeat (20) @(posedge CLK);
		for (int i = 0; i < 3; i++) begin
			chk(COLON_ON, 1'b1);
			repeat (500) @(posedge CLK);
		end
		chk(DISP_ON, 1'b0);
		u_rx_model.send({9'd1, 5'd23, 6'd0, 6'd0});
		wait_until(cyc + SEC * FRAME_S - 16);
		chk(DISP_ON, 1'b0);
		t1c = cyc;
		u_rx_model.send({9'd1, 5'd23, 6'd0, 6'd30});
		while (DISP_ON !== 1'b1) @(posedge CLK);
		chk(DISP_TIME, {9'd2, 5'd1, 6'd0, 6'd30});
		meas(1'b0, 1'b1);
		chk(n inside {[150:176]}, 1'b1);
		meas(1'b0, 1'b0);
		chk(n, 900 * MSC);
		meas(1'b0, 1'b1);
		chk(n, PPS_HIGH_MS * MSC);
		while (KHZ !== 1'b1) @(posedge CLK);
		meas(1'b1, 1'b1);
		chk(n, 1);
		meas(1'b1, 1'b0);
		chk(n, MSC - 1);
		chk(PM, 1'b0);
		rd(ADR_IRQ_STAT, 32'h3);
		chk(IRQ, 1'b1);
		wb(1'b1, ADR_IRQ_MASK, '0);
		repeat (2) @(posedge CLK);
		chk(IRQ, 1'b0);
		wb(1'b1, ADR_IRQ_STAT, 32'h1f);
		wb(1'b1, ADR_IRQ_MASK, 32'h18);
		wb(1'b1, ADR_CTRL, 32'h623b);
		repeat (3) @(posedge CLK);
		chk({DISP_TIME.day, DISP_TIME.hour, PM}, {9'd1, 5'd6, 1'b1});
		wb(1'b0, ADR_TIME, '0);
		chk(v[31:6], {6'h0, 9'd1, 5'd6, 6'd0});
		for (int i = 1; i < 4; i++) begin
			wb(1'b1, ADR_CTRL, 32'h6202 | (i << 6));
			repeat (3) @(posedge CLK);
			chk(SAT_EAST, i != 2);
		end
		wb(1'b1, ADR_CTRL, 32'h6202);
		u_rx_model.set_lock(1'b1, 1'b0, 1'b1);
		repeat (SEC * 19 / 10) @(posedge CLK);
		wb(1'b0, ADR_STATUS, '0);
		chk(v[6:5], 2'b00);
		repeat (SEC * 21 / 10) @(posedge CLK);
		wb(1'b0, ADR_STATUS, '0);
		chk({v[6:5], IRQ}, 3'b011);
		repeat (SEC * 31 / 10) @(posedge CLK);
		wb(1'b0, ADR_STATUS, '0);
		chk(v[6], 1'b1);
		rd(ADR_AGE, 32'd6);
		u_rx_model.set_lock(1'b1, 1'b1, 1'b1);
		wait_until(t1c + SEC * FRAME_S);
		u_rx_model.send({9'd1, 5'd23, 6'd1, 6'd0});
		repeat (20) @(posedge CLK);
		wb(1'b0, ADR_STATUS, '0);
		chk({v[6:5], DISP_ON}, 3'b001);
		rd(ADR_AGE, '0);
		stop_test();
	end
endmodule : test_sat_clock
